// ==== verilog/ccomc_pkg.sv ====
// Operation
// - main clock output held low while the loop is unlocked, unless run-unlocked set
// - with run-unlocked set, synthesizer clock stays routed to main output when unlocked
// - special pin tristates main for function 000/010, auxiliary for 001/010
// - in output-disable function, pin low enables outputs, pin high disables them
// - function 011: ratio modifier applied only while special pin high
// - ratio shift codes 00..11 right-shift the user ratio by one to four
// - function 111: special pin high forces auxiliary source to loop clock
// - auxiliary source 01 reference, 10 loop clock, 11 lock status; 00 reserved
// - indicator style 0 push-pull high when unlocked; style 1 open drain low
// - indicator style ignored whenever auxiliary pin carries a clock
// - auxiliary loop clock need not be phase aligned with main output
// - two select pins pick one of four sets; global settings shared
// - enable, disable and unlock gating never cut a clock period short
// - switching between sources 00 and 10 glitch-free; 01/11 may glitch
// - any select pin change drops lock while new settings apply
// - special pin change drops lock for function 011 through 110
// - unlock on reference gaps, step changes or drift beyond 30 percent
// - after lock time the configured clock is delivered
// - run-unlocked 0 forces main and auxiliary loop clock outputs low when unlocked; 1 keeps them running
package ccomc_pkg;
   // -------------------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] ADR_GLOBAL = 8'h00;
   localparam logic [7:0] ADR_SET0 = 8'h04;
   localparam logic [7:0] ADR_RATIO0 = 8'h14;
   localparam logic [7:0] ADR_STATUS = 8'h24;
   localparam logic [7:0] ADR_EFF = 8'h28;
   localparam int NUM_SETS = 4;
   // -------------------------------------------------------------
   // field layout and codes
   // -------------------------------------------------------------
   localparam int GL_RUN_UNL = 0;
   localparam int GL_STYLE = 1;
   localparam int GL_FUNC_LSB = 4;
   localparam int SET_SHIFT_LSB = 0;
   localparam int SET_AUX_LSB = 4;
   localparam logic [2:0] F_DIS_MAIN = 3'h0;
   localparam logic [2:0] F_DIS_AUX = 3'h1;
   localparam logic [2:0] F_DIS_BOTH = 3'h2;
   localparam logic [2:0] F_RMOD = 3'h3;
   localparam logic [2:0] F_RSV_HI = 3'h6;
   localparam logic [2:0] F_FORCE_PLL = 3'h7;
   localparam logic [1:0] AUX_RSV = 2'h0;
   localparam logic [1:0] AUX_REF = 2'h1;
   localparam logic [1:0] AUX_PLL = 2'h2;
   localparam logic [1:0] AUX_LOCK = 2'h3;
   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [31:0] RST_RATIO = 32'h0010_0000;
   localparam logic [1:0] RST_SHIFT = 2'h0;
   localparam logic [1:0] RST_AUX = 2'h2;
   localparam logic [2:0] RST_FUNC = 3'h0;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int RELOCK_NS = 50000;
   localparam int RELOCK_CYC = (RELOCK_NS * CLK_MHZ) / 1000;
   localparam int REF_GAP_MS = 25;
   localparam int REF_GAP_CYC = REF_GAP_MS * CLK_MHZ * 1000;
   localparam int DRIFT_PCT = 30;
   localparam int PCT_FULL = 100;
   // -------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic [1:0] ratio_shift_select;
      logic [1:0] aux_source_select;
   } ccomc_set_s;
   typedef struct packed {
      logic run_output_when_unlocked;
      logic unlock_indicator_style;
      logic [2:0] mode2_function_select;
   } ccomc_glob_s;
   typedef struct packed {
      logic special_mode_pin;
      logic config_set_select_high;
      logic config_set_select_low;
      logic ref_clk;
      logic synth_clk;
      logic pll_lock;
   } ccomc_pins_s;
endpackage : ccomc_pkg

// ==== verilog/ccomc_top.sv ====
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module ccomc_top
   import ccomc_pkg::*;
#(
   parameter int REF_GAP = REF_GAP_CYC,
   parameter int PW = 26
)(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic special_mode_pin,
   input wire logic config_set_select_high,
   input wire logic config_set_select_low,
   input wire logic ref_clk_in,
   input wire logic synth_clk_in,
   input wire logic pll_lock_in,
   output logic main_clk_o,
   output logic main_clk_oe,
   output logic aux_out_o,
   output logic aux_out_oe,
   output logic relock_req_o,
   output logic [31:0] eff_ratio_o
);
   // -------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------
   ccomc_pins_s raw, s1_q, s2_q, s3_q;
   assign raw = '{special_mode_pin, config_set_select_high, config_set_select_low,
                  ref_clk_in, synth_clk_in, pll_lock_in};
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // -------------------------------------------------------------
   // register file
   // -------------------------------------------------------------
   ccomc_glob_s glob_q;
   ccomc_set_s set_q [NUM_SETS];
   logic [31:0] ratio_q [NUM_SETS];
   logic ack_q;
   logic [31:0] dat_q;
   logic locked_q;
   logic ref_fault_q;
   logic [31:0] eff_q;
   logic [1:0] idx_q;
   wire req = wb_cyc_i & wb_stb_i;
   wire wr = req & wb_we_i & ack_q;
   // upper address bits must be zero, or the word index would alias the map
   wire [3:0] widx = (wb_adr_i[7:6] == 2'h0) ? wb_adr_i[5:2] : 4'hf;
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         ack_q <= 1'b0;
      else
         ack_q <= req & ~ack_q;
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         glob_q <= '{1'b0, 1'b0, RST_FUNC};
      else if (wr && wb_adr_i == ADR_GLOBAL && wb_sel_i[0])
         glob_q <= '{wb_dat_i[GL_RUN_UNL], wb_dat_i[GL_STYLE],
                     wb_dat_i[GL_FUNC_LSB +: 3]};
   end
   genvar g;
   generate
      for (g = 0; g < NUM_SETS; g++)
      begin : g_set
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
               set_q[g] <= '{RST_SHIFT, RST_AUX};
            else if (wr && wb_adr_i == ADR_SET0 + 8'(4 * g) && wb_sel_i[0])
               set_q[g] <= '{wb_dat_i[SET_SHIFT_LSB +: 2], wb_dat_i[SET_AUX_LSB +: 2]};
         end
         for (genvar b = 0; b < 4; b++)
         begin : g_byte
            always_ff @(posedge mclk or negedge rstn)
            begin
               if (!rstn)
                  ratio_q[g][8*b +: 8] <= RST_RATIO[8*b +: 8];
               else if (wr && wb_adr_i == ADR_RATIO0 + 8'(4 * g) && wb_sel_i[b])
                  ratio_q[g][8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
         end
      end
   endgenerate
   // unmapped addresses read zero and still get an ack
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         dat_q <= '0;
      else if (req && !ack_q)
      begin
         dat_q <= '0;
         if (wb_adr_i[1:0] == 2'h0)
         begin
            if (wb_adr_i == ADR_GLOBAL)
               dat_q <= 32'({glob_q.mode2_function_select, 2'h0,
                             glob_q.unlock_indicator_style, glob_q.run_output_when_unlocked});
            else if (widx >= 4'h1 && widx <= 4'h4)
               dat_q <= 32'({set_q[2'(widx - 4'h1)].aux_source_select, 2'h0,
                             set_q[2'(widx - 4'h1)].ratio_shift_select});
            else if (widx >= 4'h5 && widx <= 4'h8)
               dat_q <= ratio_q[2'(widx - 4'h5)];
            else if (wb_adr_i == ADR_STATUS)
               dat_q <= 32'({idx_q, ref_fault_q, s2_q.pll_lock, locked_q});
            else if (wb_adr_i == ADR_EFF)
               dat_q <= eff_q;
         end
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   // -------------------------------------------------------------
   // set selection and relock hold
   // -------------------------------------------------------------
   logic [11:0] relock_q;
   logic relock_pulse_q;
   wire [2:0] func = glob_q.mode2_function_select;
   wire m2 = s2_q.special_mode_pin;
   wire sel_chg = (s2_q.config_set_select_high != s3_q.config_set_select_high) |
                  (s2_q.config_set_select_low != s3_q.config_set_select_low);
   wire m2_chg = (s2_q.special_mode_pin != s3_q.special_mode_pin) &
                 (func >= F_RMOD) & (func <= F_RSV_HI);
   logic ref_fault_ev;
   wire relock_start = sel_chg | m2_chg | ref_fault_ev;
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         idx_q <= 2'h0;
      else
         idx_q <= {s2_q.config_set_select_high, s2_q.config_set_select_low};
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         relock_q <= 12'(RELOCK_CYC);
      else if (relock_start)
         relock_q <= 12'(RELOCK_CYC);
      else if (relock_q != 12'h0)
         relock_q <= relock_q - 12'h1;
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         relock_pulse_q <= 1'b0;
      else
         relock_pulse_q <= relock_start;
   end
   assign relock_req_o = relock_pulse_q;
   // the analog loop's own lock flag is qualified by our hold and monitor
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         locked_q <= 1'b0;
      else
         locked_q <= s2_q.pll_lock & (relock_q == 12'h0) & ~relock_start;
   end
   // -------------------------------------------------------------
   // reference monitor
   // -------------------------------------------------------------
   logic [PW-1:0] per_cnt_q, start_per_q;
   logic have_start_q;
   wire ref_rise = s2_q.ref_clk & ~s3_q.ref_clk;
   wire [PW+7:0] now_x = (PW+8)'(per_cnt_q) * (PW+8)'(PCT_FULL);
   wire [PW+7:0] hi_x = (PW+8)'(start_per_q) * (PW+8)'(PCT_FULL + DRIFT_PCT);
   wire [PW+7:0] lo_x = (PW+8)'(start_per_q) * (PW+8)'(PCT_FULL - DRIFT_PCT);
   wire gap = per_cnt_q >= PW'(REF_GAP);
   always_comb
   begin
      ref_fault_ev = gap;
      if (ref_rise && have_start_q && (now_x > hi_x || now_x < lo_x))
         ref_fault_ev = 1'b1;
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         per_cnt_q <= '0;
      else if (ref_rise || gap)
         per_cnt_q <= '0;
      else
         per_cnt_q <= per_cnt_q + PW'(1);
   end
   // starting period taken at the first full period after lock
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         have_start_q <= 1'b0;
         start_per_q <= '0;
      end
      else if (ref_fault_ev || sel_chg)
         have_start_q <= 1'b0;
      else if (ref_rise && !have_start_q && relock_q == 12'h0 && per_cnt_q != '0)
      begin
         have_start_q <= 1'b1;
         start_per_q <= per_cnt_q;
      end
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         ref_fault_q <= 1'b0;
      else if (ref_fault_ev)
         ref_fault_q <= 1'b1;
      else if (wr && wb_adr_i == ADR_STATUS && wb_dat_i[2])
         ref_fault_q <= 1'b0;
   end
   // -------------------------------------------------------------
   // effective ratio
   // -------------------------------------------------------------
   wire rmod_en = (func == F_RMOD) & m2;
   wire [2:0] shamt = {1'b0, set_q[idx_q].ratio_shift_select} + 3'h1;
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         eff_q <= RST_RATIO;
      else if (rmod_en)
         eff_q <= ratio_q[idx_q] >> shamt;
      else
         eff_q <= ratio_q[idx_q];
   end
   assign eff_ratio_o = eff_q;
   // -------------------------------------------------------------
   // main clock output
   // -------------------------------------------------------------
   logic main_q, main_oe_q, main_run_q;
   wire syn = s2_q.synth_clk;
   wire run_ok = locked_q | glob_q.run_output_when_unlocked;
   wire m2_dis = m2 & (func <= F_DIS_BOTH);
   wire main_dis = m2_dis & (func != F_DIS_AUX);
   wire aux_dis = m2_dis & (func != F_DIS_MAIN);
   // gate decisions only move while source and pin are both low
   wire main_low = ~syn & ~main_q;
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         main_run_q <= 1'b0;
         main_oe_q <= 1'b1;
      end
      else if (main_low)
      begin
         main_run_q <= run_ok;
         main_oe_q <= ~main_dis;
      end
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         main_q <= 1'b0;
      else
         main_q <= syn & main_run_q;
   end
   assign main_clk_o = main_q;
   assign main_clk_oe = main_oe_q;
   // -------------------------------------------------------------
   // auxiliary output
   // -------------------------------------------------------------
   logic [1:0] asel_q;
   logic aux_q, aux_oe_q, aux_run_q;
   wire [1:0] want_src = (func == F_FORCE_PLL && m2) ? AUX_PLL
                         : set_q[idx_q].aux_source_select;
   wire cur_pll = asel_q == AUX_PLL || asel_q == AUX_RSV;
   wire new_pll = want_src == AUX_PLL || want_src == AUX_RSV;
   wire aux_low = ~aux_q & ~syn;
   // pll to pll waits for a low phase; ref and lock paths accept a runt
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         asel_q <= RST_AUX;
      else if (!(cur_pll && new_pll) || aux_low)
         asel_q <= want_src;
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         aux_run_q <= 1'b0;
      else if (aux_low)
         aux_run_q <= run_ok;
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         aux_q <= 1'b0;
         aux_oe_q <= 1'b1;
      end
      else
      begin
         unique case (asel_q)
            AUX_REF:
            begin
               aux_q <= s2_q.ref_clk;
               // enable moves in a low phase so a reference period is never cut
               if (!aux_q && !s2_q.ref_clk)
                  aux_oe_q <= ~aux_dis;
            end
            AUX_LOCK:
            begin
               aux_q <= glob_q.unlock_indicator_style ? 1'b0 : ~locked_q;
               aux_oe_q <= ~aux_dis & (~glob_q.unlock_indicator_style | ~locked_q);
            end
            default:
            begin
               // own copy of the gated loop clock, no phase tie to main
               aux_q <= syn & aux_run_q;
               if (aux_low)
                  aux_oe_q <= ~aux_dis;
            end
         endcase
      end
   end
   assign aux_out_o = aux_q;
   assign aux_out_oe = aux_oe_q;
   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   logic main_q_d1;
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         main_q_d1 <= 1'b0;
      else
         main_q_d1 <= main_q;
   end
   a_main_low_unlk: assert property (@(posedge mclk) disable iff (!rstn)
      (!run_ok && main_low) |=> ##1 !main_q)
      else $error("main output toggled while unlocked");
   a_main_run_unlk: assert property (@(posedge mclk) disable iff (!rstn)
      (glob_q.run_output_when_unlocked && main_low && $stable(glob_q))
         ##1 (syn && main_run_q) |=> main_q)
      else $error("main output not running with run-unlocked");
   a_main_tri_fn: assert property (@(posedge mclk) disable iff (!rstn)
      (main_low && main_dis) |=> !main_clk_oe)
      else $error("main output not tristated");
   a_aux_tri_fn: assert property (@(posedge mclk) disable iff (!rstn)
      (asel_q == AUX_REF && !aux_dis && !aux_q && !s2_q.ref_clk) |=> aux_out_oe)
      else $error("aux output disabled with pin low");
   a_rmod_gate: assert property (@(posedge mclk) disable iff (!rstn)
      !rmod_en |=> eff_q == $past(ratio_q[idx_q]))
      else $error("ratio modified without enable");
   a_rmod_shift: assert property (@(posedge mclk) disable iff (!rstn)
      rmod_en |=> eff_q == ($past(ratio_q[idx_q]) >> ($past(shamt))))
      else $error("ratio shift wrong");
   a_aux_force: assert property (@(posedge mclk) disable iff (!rstn)
      (func == F_FORCE_PLL && m2 && aux_low) |=> asel_q == AUX_PLL)
      else $error("aux not forced to loop clock");
   a_lock_style: assert property (@(posedge mclk) disable iff (!rstn)
      (asel_q == AUX_LOCK && glob_q.unlock_indicator_style && $stable(asel_q))
         |=> !aux_out_o)
      else $error("open drain indicator drove high");
   a_no_runt: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(main_q) |=> main_q || !syn)
      else $error("main output runt pulse");
   a_relock_sel: assert property (@(posedge mclk) disable iff (!rstn)
      sel_chg |=> !locked_q ##1 !locked_q)
      else $error("lock kept across set change");
   a_relock_m2: assert property (@(posedge mclk) disable iff (!rstn)
      m2_chg |=> relock_q == 12'(RELOCK_CYC))
      else $error("special pin change did not hold relock");
   a_ref_gap: assert property (@(posedge mclk) disable iff (!rstn)
      gap |=> !locked_q && ref_fault_q)
      else $error("reference gap not flagged");
   a_set_pick: assert property (@(posedge mclk) disable iff (!rstn)
      1'b1 |=> idx_q == $past({s2_q.config_set_select_high, s2_q.config_set_select_low}))
      else $error("set index not following pins");
   c_relock: cover property (@(posedge mclk) disable iff (!rstn) sel_chg ##[1:8] 1'b1);
   c_lock_gain: cover property (@(posedge mclk) disable iff (!rstn) $rose(locked_q));
   c_aux_switch: cover property (@(posedge mclk) disable iff (!rstn)
      $changed(asel_q) && asel_q == AUX_REF);
   c_rmod: cover property (@(posedge mclk) disable iff (!rstn)
      rmod_en && set_q[idx_q].ratio_shift_select == 2'h3);
endmodule : ccomc_top
`default_nettype wire

// ==== verif/ccomc_board_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccomc_board_model (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic lock_ok,
   input wire logic ref_run,
   output logic synth_clk,
   output logic ref_clk,
   output logic pll_lock
);
   // ---------------------------------
   // clocks of the board
   // ---------------------------------
   logic [1:0] sdiv_q;
   logic [2:0] rdiv_q;
   logic synth_q;
   logic ref_q;
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
      begin
         sdiv_q <= 2'h0;
         synth_q <= 1'b0;
      end
      else
      begin
         sdiv_q <= sdiv_q + 2'h1;
         if (sdiv_q == 2'h3) synth_q <= ~synth_q;
      end
   // ref held steady in reset, applied only after it
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
      begin
         rdiv_q <= 3'h0;
         ref_q <= 1'b0;
      end
      else
      begin
         rdiv_q <= (rdiv_q == 3'h4) ? 3'h0 : rdiv_q + 3'h1;
         if (ref_run && rdiv_q == 3'h4) ref_q <= ~ref_q;
      end
   assign synth_clk = synth_q;
   assign ref_clk = ref_q;
   assign pll_lock = lock_ok & rstn;
endmodule : ccomc_board_model
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ccomc_pkg::*;
   logic mclk, rstn, cyc, stb, we, pin, csh, csl, lock_ok, ref_run;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, r, dat_o, eff;
   logic ack, mclk_o, moe, aux, aoe, rlk, synth, refc, plock;
   int miscompares, samples_checked;
   // ---------------------------------
   // instances
   // ---------------------------------
   ccomc_board_model BRD (.mclk(mclk), .rstn(rstn), .lock_ok(lock_ok), .ref_run(ref_run),
      .synth_clk(synth), .ref_clk(refc), .pll_lock(plock));
   // short fault window keeps the reference gap test brief
   ccomc_top #(.REF_GAP(200)) DUT (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .special_mode_pin(pin), .config_set_select_high(csh),
      .config_set_select_low(csl), .ref_clk_in(refc), .synth_clk_in(synth),
      .pll_lock_in(plock), .main_clk_o(mclk_o), .main_clk_oe(moe), .aux_out_o(aux),
      .aux_out_oe(aoe), .relock_req_o(rlk), .eff_ratio_o(eff));
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // ---------------------------------
   // helpers
   // ---------------------------------
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task cyc_n(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc_n
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 16);
      r = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
      if (n >= 16)
      begin
         chk(32'h0, 32'h1, "no ack");
         close_out;
      end
   endtask : wb
   task rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
      wb(1'b0, a, 32'h0);
      chk(r, e, m);
   endtask : rd_chk
   task toggles(input logic which, input logic run, input string m);
      int n;
      logic p, v;
      n = 0;
      p = which ? aux : mclk_o;
      repeat (48)
      begin
         @(posedge mclk);
         v = which ? aux : mclk_o;
         if (v !== p) n++;
         p = v;
      end
      chk({31'h0, n != 0}, {31'h0, run}, m);
   endtask : toggles
   task pulse(input logic which, input string m);
      int n;
      @(posedge mclk);
      if (which) csl <= ~csl;
      else pin <= ~pin;
      n = 0;
      repeat (10)
      begin
         @(posedge mclk);
         if (rlk === 1'b1) n++;
      end
      chk(n, 32'h1, m);
   endtask : pulse
   task wait_lock;
      int i;
      i = 0;
      do
      begin
         wb(1'b0, ADR_STATUS, 32'h0);
         i++;
      end while (r[0] !== 1'b1 && i < 1500);
      if (i >= 1500)
      begin
         chk(32'h0, 32'h1, "lock wait");
         close_out;
      end
   endtask : wait_lock
   // ---------------------------------
   // scenarios
   // ---------------------------------
   task t_regs;
      rd_chk(ADR_GLOBAL, 32'h0, "global rst");
      rd_chk(ADR_SET0, {26'h0, RST_AUX, 2'h0, RST_SHIFT}, "set rst");
      rd_chk(ADR_RATIO0 + 8'hc, RST_RATIO, "ratio rst");
      rd_chk(8'h3c, 32'h0, "unmapped");
      rd_chk(8'h44, 32'h0, "alias");
   endtask : t_regs
   task t_gate;
      toggles(1'b0, 1'b0, "main gated");
      wb(1'b1, ADR_GLOBAL, 32'h1);
      cyc_n(8);
      toggles(1'b0, 1'b1, "run unlocked");
      wb(1'b1, ADR_GLOBAL, 32'h0);
   endtask : t_gate
   task t_disable;
      for (int f = 0; f < 3; f++)
      begin
         wb(1'b1, ADR_GLOBAL, 32'(f) << 4);
         pin <= 1'b1;
         cyc_n(20);
         chk(moe, f == 1, "main oe");
         chk(aoe, f == 0, "aux oe");
         pin <= 1'b0;
         cyc_n(20);
         chk({moe, aoe}, 2'h3, "oe on");
      end
   endtask : t_disable
   task t_rmod;
      wb(1'b1, ADR_RATIO0, 32'h0123_4567);
      wb(1'b1, ADR_GLOBAL, {F_RMOD, 4'h0});
      cyc_n(6);
      chk(eff, 32'h0123_4567, "no mod");
      pulse(1'b0, "rmod relock");
      for (int k = 0; k < 4; k++)
      begin
         wb(1'b1, ADR_SET0, 32'h20 | k);
         cyc_n(6);
         chk(eff, 32'h0123_4567 >> (k + 1), "shift");
      end
      pulse(1'b0, "rmod off");
      cyc_n(6);
      chk(eff, 32'h0123_4567, "mod off");
      rd_chk(ADR_EFF, 32'h0123_4567, "eff read");
   endtask : t_rmod
   task t_aux;
      wait_lock;
      wb(1'b1, ADR_GLOBAL, 32'h0);
      wb(1'b1, ADR_SET0, 32'h30);
      wb(1'b1, ADR_SET0 + 8'h4, 32'h30);
      cyc_n(8);
      chk({aux, aoe}, 2'h1, "pp locked");
      wb(1'b1, ADR_GLOBAL, 32'h2);
      cyc_n(8);
      chk(aoe, 1'b0, "od float");
      pulse(1'b1, "set relock");
      chk({aux, aoe}, 2'h1, "od low");
      rd_chk(ADR_STATUS, 32'h0a, "status idx");
      wb(1'b1, ADR_GLOBAL, 32'h0);
      cyc_n(8);
      chk({aux, aoe}, 2'h3, "pp high");
      wb(1'b1, ADR_GLOBAL, {F_FORCE_PLL, 4'h3});
      pin <= 1'b1;
      cyc_n(8);
      toggles(1'b1, 1'b1, "force pll");
      wait_lock;
      chk(aoe, 1'b1, "style ignored");
      pin <= 1'b0;
      wb(1'b1, ADR_SET0 + 8'h4, 32'h10);
      cyc_n(8);
      toggles(1'b1, 1'b1, "ref source");
   endtask : t_aux
   task t_refgap;
      ref_run <= 1'b0;
      cyc_n(300);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk({r[2], r[0]}, 2'h2, "ref gap");
      ref_run <= 1'b1;
      cyc_n(20);
      wb(1'b1, ADR_STATUS, 32'h4);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(r[2], 1'b0, "fault clear");
   endtask : t_refgap
   initial
   begin
      rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h0; sel = 4'h0;
      wdat = 32'h0; pin = 1'b0; csh = 1'b0; csl = 1'b0; lock_ok = 1'b1; ref_run = 1'b1;
      miscompares = 0; samples_checked = 0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      t_regs;
      t_gate;
      repeat (4)
      begin
         @(posedge mclk);
         csl <= ~csl;
         cyc_n(4);
      end
      wait_lock;
      toggles(1'b0, 1'b1, "locked main");
      t_disable;
      t_rmod;
      t_aux;
      t_refgap;
      close_out;
   end
endmodule : tb_top
`default_nettype wire
